// *** ssm_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
module ssm_monitor #(
    parameter int GATE_LEN = ssm_pkg::GATE_CYCLES
) (
    // clock and reset
    input wire logic clock,
    input wire logic resetn,
    // axi4-lite write
    input wire logic [ssm_pkg::ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [ssm_pkg::DATA_W-1:0] wdata,
    input wire logic [ssm_pkg::STRB_W-1:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // axi4-lite read
    input wire logic [ssm_pkg::ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [ssm_pkg::DATA_W-1:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // sensors
    input wire logic enc1A,
    input wire logic enc1B,
    input wire logic enc2A,
    input wire logic prox1,
    input wire logic prox2,
    // threshold select
    input wire logic threshold_sel_bit0,
    input wire logic threshold_sel_bit1,
    input wire logic threshold_sel_bit2,
    // results
    output logic zeroSpeed,
    output logic overOk,
    output logic direction,
    output logic irq
);
    import ssm_pkg::*;

    logic [DATA_W-1:0] ctrl;
    logic [LIM_W-1:0] zeroLimit;
    logic [HYST_W-1:0] hyst;
    logic [GEAR_W-1:0] gear;
    logic [RES_W-1:0] res1;
    logic [RES_W-1:0] res2;
    logic [RES_W-1:0] pitch;
    logic [LIM_W-1:0] thr [THR_N];
    logic [IRQ_W-1:0] irqStat;
    logic [IRQ_W-1:0] irqMask;
    logic awGot;
    logic wGot;
    logic [ADDR_W-1:0] awAddrQ;
    logic [DATA_W-1:0] wDataQ;
    logic [STRB_W-1:0] wStrbQ;
    logic doWrite;
    logic rdClear;
    logic [DATA_W-1:0] rdMux;
    logic rdHit;
    logic wrHit;
    ssm_scale_t scale;
    ssm_arr_t arr;
    ssm_dir_t dirDec;
    logic useEnc1;
    logic twoSensors;
    logic proxNc;
    logic p1Lvl;
    logic p2Lvl;
    logic enc1APrev;
    logic enc2APrev;
    logic p1Prev;
    logic p2Prev;
    logic pulse1;
    logic pulse2;
    logic [GATE_W-1:0] gateCnt;
    logic [CNT_W-1:0] acc1;
    logic [CNT_W-1:0] acc2;
    logic [CNT_W-1:0] cnt1;
    logic [CNT_W-1:0] cnt2;
    logic measDone;
    logic measValid;
    logic dirCcw;
    logic [SEL_W-1:0] thrM1;
    logic [SEL_W-1:0] selCode;
    logic [SEL_W-1:0] thrIdx;
    logic [1:0] zA;
    logic [1:0] zB;
    logic [1:0] oA;
    logic [1:0] oB;
    logic zBelowLo;
    logic zExceed;
    logic oBelowLo;
    logic oExceed;
    logic dirBlocked;
    logic next_zeroSpeed;
    logic next_overOk;
    logic [IRQ_W-1:0] next_irqStat;

    function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old, input logic [DATA_W-1:0] wd,
                                                input logic [STRB_W-1:0] strb);
        logic [DATA_W-1:0] r;
        r = old;
        for (int i = 0; i < STRB_W; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // sensor-side term: pulses scaled by mode
    function automatic logic [63:0] lhsOf(input logic [CNT_W-1:0] n, input logic [RES_W-1:0] res,
                                          input logic [RES_W-1:0] pit, input ssm_scale_t sc);
        logic [63:0] r;
        unique case (sc)
            SC_ROT_ROT: r = 64'(n) * K_SEC_PER_MIN * K_GEAR_DIV;
            SC_LIN_ROT: r = 64'(n) * K_SEC_PER_MIN * 64'(pit) * K_GEAR_DIV;
            SC_LIN_LIN: r = 64'(n) * 64'(res) * K_GEAR_DIV;
        endcase
        return r;
    endfunction

    // limit-side term: speed limit in sensor-side units (pulses per minute when rotary), times gear
    function automatic logic [63:0] rhsOf(input logic [LIM_W-1:0] lim, input logic [RES_W-1:0] res,
                                          input logic [GEAR_W-1:0] g, input ssm_scale_t sc);
        logic [63:0] r;
        unique case (sc)
            SC_ROT_ROT: r = 64'(lim) * 64'(res) * 64'(g);
            SC_LIN_ROT: r = 64'(lim) * K_MILLI * 64'(res) * 64'(g);
            SC_LIN_LIN: r = 64'(lim) * K_MILLI * 64'(g);
        endcase
        return r;
    endfunction

    // returns {below lower hysteresis bound, above upper bound}
    function automatic logic [1:0] judge(input logic [63:0] lhs, input logic [63:0] rhs,
                                         input logic [HYST_W-1:0] h);
        logic [63:0] pct;
        pct = (h > HYST_MAX) ? 64'(HYST_MAX) : 64'(h);
        return {(lhs * K_PCT) < (rhs * (K_PCT - pct)), lhs > rhs};
    endfunction

    // configuration decode
    always_comb begin
        if (!ctrl[CTRL_AXIS_LIN]) begin
            scale = SC_ROT_ROT;
        end else if (ctrl[CTRL_SENS_LIN]) begin
            scale = SC_LIN_LIN;
        end else begin
            scale = SC_LIN_ROT;
        end
    end

    always_comb begin
        if (ctrl[CTRL_ARR_LO +: 3] > ARR_ENC_ENC) begin
            arr = ARR_ENC;
        end else begin
            arr = ssm_arr_t'(ctrl[CTRL_ARR_LO +: 3]);
        end
    end

    assign dirDec = ssm_dir_t'(ctrl[CTRL_DIR_LO +: 2]);
    assign useEnc1 = (arr == ARR_ENC) || (arr == ARR_ENC_PROX) || (arr == ARR_ENC_ENC);
    assign twoSensors = (arr == ARR_ENC_PROX) || (arr == ARR_PROX_PROX) || (arr == ARR_ENC_ENC);
    assign proxNc = ctrl[CTRL_PROX_NC];
    assign p1Lvl = prox1 ^ proxNc;
    assign p2Lvl = prox2 ^ proxNc;

    // pulse sources
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            enc1APrev <= 1'b0;
            enc2APrev <= 1'b0;
            p1Prev <= 1'b0;
            p2Prev <= 1'b0;
        end else begin
            enc1APrev <= enc1A;
            enc2APrev <= enc2A;
            p1Prev <= p1Lvl;
            p2Prev <= p2Lvl;
        end
    end

    always_comb begin
        pulse1 = useEnc1 ? (enc1A && !enc1APrev) : (p1Lvl && !p1Prev);
        unique case (arr)
            ARR_ENC_PROX: pulse2 = p1Lvl && !p1Prev;
            ARR_PROX_PROX: pulse2 = p2Lvl && !p2Prev;
            ARR_ENC_ENC: pulse2 = enc2A && !enc2APrev;
            default: pulse2 = 1'b0;
        endcase
    end

    // direction from quadrature phase
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            dirCcw <= 1'b0;
        end else if (useEnc1 && enc1A && !enc1APrev) begin
            dirCcw <= enc1B;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            direction <= 1'b0;
        end else begin
            direction <= ctrl[CTRL_DIR_EN] && useEnc1 && dirCcw;
        end
    end

    // gate timer and pulse counters
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            gateCnt <= '0;
            acc1 <= '0;
            acc2 <= '0;
            cnt1 <= '0;
            cnt2 <= '0;
            measDone <= 1'b0;
            measValid <= 1'b0;
        end else if (gateCnt == GATE_W'(GATE_LEN - 1)) begin
            gateCnt <= '0;
            cnt1 <= acc1 + CNT_W'(pulse1);
            cnt2 <= acc2 + CNT_W'(pulse2);
            acc1 <= '0;
            acc2 <= '0;
            measDone <= 1'b1;
            measValid <= 1'b1;
        end else begin
            gateCnt <= gateCnt + 1'b1;
            acc1 <= acc1 + CNT_W'(pulse1);
            acc2 <= acc2 + CNT_W'(pulse2);
            measDone <= 1'b0;
        end
    end

    // threshold selection
    always_comb begin
        thrM1 = ctrl[CTRL_THR_LO +: SEL_W];
        if (ctrl[CTRL_LEGACY] && thrM1 > THR_LEGACY_M1) begin
            thrM1 = THR_LEGACY_M1;
        end
        selCode = {threshold_sel_bit2, threshold_sel_bit1, threshold_sel_bit0};
        if (thrM1 == '0) begin
            thrIdx = '0;
        end else if (thrM1 == 3'h1) begin
            thrIdx = {2'h0, selCode[0]};
        end else if (thrM1 <= 3'h3) begin
            thrIdx = {1'h0, selCode[1:0]};
        end else begin
            thrIdx = selCode;
        end
        if (thrIdx > thrM1) begin
            thrIdx = thrM1;
        end
    end

    // comparisons; second sensor carries the gear ratio
    assign zA = judge(lhsOf(cnt1, res1, pitch, scale), rhsOf(zeroLimit, res1, GEAR_UNITY, scale), hyst);
    assign zB = judge(lhsOf(cnt2, res2, pitch, scale), rhsOf(zeroLimit, res2, gear, scale), hyst);
    assign oA = judge(lhsOf(cnt1, res1, pitch, scale), rhsOf(thr[thrIdx], res1, GEAR_UNITY, scale), hyst);
    assign oB = judge(lhsOf(cnt2, res2, pitch, scale), rhsOf(thr[thrIdx], res2, gear, scale), hyst);
    assign zBelowLo = zA[1] && (!twoSensors || zB[1]);
    assign zExceed = zA[0] || (twoSensors && zB[0]);
    assign oBelowLo = oA[1] && (!twoSensors || oB[1]);
    assign oExceed = oA[0] || (twoSensors && oB[0]);
    assign dirBlocked = useEnc1 && (((dirDec == DIR_CW) && dirCcw) || ((dirDec == DIR_CCW) && !dirCcw));

    always_comb begin
        next_zeroSpeed = zeroSpeed;
        next_overOk = overOk;
        if (!measValid) begin
            next_zeroSpeed = 1'b0;
            next_overOk = 1'b0;
        end else if (measDone) begin
            if (zBelowLo) begin
                next_zeroSpeed = 1'b1;
            end else if (zExceed) begin
                next_zeroSpeed = 1'b0;
            end
            if (dirBlocked || oBelowLo) begin
                next_overOk = 1'b1;
            end else if (oExceed) begin
                next_overOk = 1'b0;
            end
        end
        if (!ctrl[CTRL_SPEED_EN]) begin
            next_overOk = 1'b0;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            zeroSpeed <= 1'b0;
            overOk <= 1'b0;
        end else begin
            zeroSpeed <= next_zeroSpeed;
            overOk <= next_overOk;
        end
    end

    // interrupt status: set wins over read clear
    always_comb begin
        next_irqStat = rdClear ? '0 : irqStat;
        next_irqStat[IRQ_ZERO] = next_irqStat[IRQ_ZERO] | (next_zeroSpeed != zeroSpeed);
        next_irqStat[IRQ_OVER] = next_irqStat[IRQ_OVER] | (next_overOk != overOk);
        next_irqStat[IRQ_MEAS] = next_irqStat[IRQ_MEAS] | measDone;
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            irqStat <= '0;
            irq <= 1'b0;
        end else begin
            irqStat <= next_irqStat;
            irq <= |(next_irqStat & irqMask);
        end
    end

    // bus write channel
    assign doWrite = awGot && wGot && !bvalid;

    always_comb begin
        wrHit = 1'b1;
        if (awAddrQ[ADDR_W-1:5] != THR_PAGE) begin
            unique case (awAddrQ)
                OFF_CTRL, OFF_ZERO, OFF_HYST, OFF_GEAR, OFF_RES1, OFF_RES2, OFF_PITCH, OFF_STATUS,
                OFF_IRQ_STAT, OFF_IRQ_MASK, OFF_COUNT1, OFF_COUNT2: wrHit = 1'b1;
                default: wrHit = 1'b0;
            endcase
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            awready <= 1'b1;
            wready <= 1'b1;
            awGot <= 1'b0;
            wGot <= 1'b0;
            awAddrQ <= '0;
            wDataQ <= '0;
            wStrbQ <= '0;
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
        end else begin
            if (awvalid && awready) begin
                awGot <= 1'b1;
                awready <= 1'b0;
                awAddrQ <= awaddr;
            end
            if (wvalid && wready) begin
                wGot <= 1'b1;
                wready <= 1'b0;
                wDataQ <= wdata;
                wStrbQ <= wstrb;
            end
            if (doWrite) begin
                awGot <= 1'b0;
                wGot <= 1'b0;
                bvalid <= 1'b1;
                bresp <= wrHit ? RESP_OKAY : RESP_DECERR;
            end
            if (bvalid && bready) begin
                bvalid <= 1'b0;
                awready <= 1'b1;
                wready <= 1'b1;
            end
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            ctrl <= CTRL_RST;
            zeroLimit <= LIMIT_RST;
            hyst <= HYST_RST;
            gear <= GEAR_UNITY;
            res1 <= RES_RST;
            res2 <= RES_RST;
            pitch <= RES_RST;
            irqMask <= '0;
        end else if (doWrite) begin
            unique case (awAddrQ)
                OFF_CTRL: ctrl <= merge(ctrl, wDataQ, wStrbQ);
                OFF_ZERO: zeroLimit <= LIM_W'(merge(DATA_W'(zeroLimit), wDataQ, wStrbQ));
                OFF_HYST: hyst <= HYST_W'(merge(DATA_W'(hyst), wDataQ, wStrbQ));
                OFF_GEAR: gear <= GEAR_W'(merge(DATA_W'(gear), wDataQ, wStrbQ));
                OFF_RES1: res1 <= RES_W'(merge(DATA_W'(res1), wDataQ, wStrbQ));
                OFF_RES2: res2 <= RES_W'(merge(DATA_W'(res2), wDataQ, wStrbQ));
                OFF_PITCH: pitch <= RES_W'(merge(DATA_W'(pitch), wDataQ, wStrbQ));
                OFF_IRQ_MASK: irqMask <= IRQ_W'(merge(DATA_W'(irqMask), wDataQ, wStrbQ));
                default: ;
            endcase
        end
    end

    generate
        for (genvar i = 0; i < THR_N; i++) begin : gThr
            always_ff @(posedge clock or negedge resetn) begin
                if (!resetn) begin
                    thr[i] <= LIMIT_RST;
                end else if (doWrite && awAddrQ[ADDR_W-1:5] == THR_PAGE && awAddrQ[4:2] == SEL_W'(i)) begin
                    thr[i] <= LIM_W'(merge(DATA_W'(thr[i]), wDataQ, wStrbQ));
                end
            end
        end
    endgenerate

    // bus read channel
    always_comb begin
        rdHit = 1'b1;
        rdMux = '0;
        if (araddr[ADDR_W-1:5] == THR_PAGE) begin
            rdMux = DATA_W'(thr[araddr[4:2]]);
        end else begin
            unique case (araddr)
                OFF_CTRL: rdMux = ctrl;
                OFF_ZERO: rdMux = DATA_W'(zeroLimit);
                OFF_HYST: rdMux = DATA_W'(hyst);
                OFF_GEAR: rdMux = DATA_W'(gear);
                OFF_RES1: rdMux = DATA_W'(res1);
                OFF_RES2: rdMux = DATA_W'(res2);
                OFF_PITCH: rdMux = DATA_W'(pitch);
                OFF_STATUS: begin
                    rdMux[ST_ZERO] = zeroSpeed;
                    rdMux[ST_OVER] = overOk;
                    rdMux[ST_DIR] = direction;
                    rdMux[ST_VALID] = measValid;
                    rdMux[ST_IDX_LO +: SEL_W] = thrIdx;
                end
                OFF_IRQ_STAT: rdMux = DATA_W'(irqStat);
                OFF_IRQ_MASK: rdMux = DATA_W'(irqMask);
                OFF_COUNT1: rdMux = DATA_W'(cnt1);
                OFF_COUNT2: rdMux = DATA_W'(cnt2);
                default: rdHit = 1'b0;
            endcase
        end
    end

    assign rdClear = arvalid && arready && (araddr == OFF_IRQ_STAT);

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            arready <= 1'b1;
            rvalid <= 1'b0;
            rdata <= '0;
            rresp <= RESP_OKAY;
        end else if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid <= 1'b1;
            rdata <= rdMux;
            rresp <= rdHit ? RESP_OKAY : RESP_DECERR;
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
            arready <= 1'b1;
        end
    end

    // checks
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!resetn);

    safe_state_a: assert property (!measValid |=> !zeroSpeed && !overOk)
        else $error("outputs not safe before first measurement");
    zero_set_a: assert property (measDone && zBelowLo |=> zeroSpeed)
        else $error("standstill not asserted below limit");
    zero_clr_a: assert property (measDone && zExceed && !zBelowLo |=> !zeroSpeed)
        else $error("standstill kept above limit");
    over_clr_a: assert property (measDone && oExceed && !oBelowLo && !dirBlocked |=> !overOk)
        else $error("over output kept above threshold");
    over_off_a: assert property (!ctrl[CTRL_SPEED_EN] |=> !overOk)
        else $error("over output active with speed check off");
    dir_qual_a: assert property (measValid && measDone && dirBlocked && ctrl[CTRL_SPEED_EN] |=> overOk)
        else $error("threshold acted in unselected direction");
    dir_out_a: assert property (!ctrl[CTRL_DIR_EN] ##1 !ctrl[CTRL_DIR_EN] |-> !direction)
        else $error("direction output present while disabled");
    thr_idx_a: assert property (thrIdx <= thrM1 && (thrM1 != '0 || thrIdx == '0))
        else $error("threshold index out of configured range");
    legacy_cap_a: assert property (ctrl[CTRL_LEGACY] |-> thrM1 <= THR_LEGACY_M1)
        else $error("legacy threshold count exceeded");
    hyst_hold_a: assert property (measDone && measValid && !zBelowLo && !zExceed |=> $stable(zeroSpeed))
        else $error("standstill toggled inside hysteresis band");
    gear_one_a: assert property (measDone && twoSensors && zB[0] |=> !zeroSpeed)
        else $error("second sensor excess ignored");

    zero_rise_c: cover property (!zeroSpeed ##1 zeroSpeed);
    over_fall_c: cover property (overOk ##1 !overOk);
    irq_fire_c: cover property (!irq ##1 irq);
    two_sense_c: cover property (measDone && twoSensors && zBelowLo);
endmodule
`default_nettype wire

// *** ssm_pkg.sv ***
`default_nettype none
package ssm_pkg;
    // clocking and measurement gate
    localparam int CLK_HZ = 20_000_000;
    localparam int MS_PER_S = 1000;
    localparam int GATE_MS = 1000;
    localparam int GATE_CYCLES = (CLK_HZ / MS_PER_S) * GATE_MS;
    localparam int GATE_W = 25;
    // widths
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int STRB_W = 4;
    localparam int CNT_W = 24;
    localparam int LIM_W = 16;
    localparam int RES_W = 16;
    localparam int GEAR_W = 10;
    localparam int HYST_W = 7;
    localparam int THR_N = 8;
    localparam int SEL_W = 3;
    localparam int IRQ_W = 3;
    // register byte offsets
    localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_ZERO = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_HYST = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_GEAR = 8'h0c;
    localparam logic [ADDR_W-1:0] OFF_RES1 = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_RES2 = 8'h14;
    localparam logic [ADDR_W-1:0] OFF_PITCH = 8'h18;
    localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h1c;
    localparam logic [ADDR_W-1:0] OFF_IRQ_STAT = 8'h20;
    localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 8'h24;
    localparam logic [ADDR_W-1:0] OFF_COUNT1 = 8'h28;
    localparam logic [ADDR_W-1:0] OFF_COUNT2 = 8'h2c;
    localparam logic [2:0] THR_PAGE = 3'h2;
    // control register fields
    localparam int CTRL_AXIS_LIN = 0;
    localparam int CTRL_SENS_LIN = 1;
    localparam int CTRL_ARR_LO = 2;
    localparam int CTRL_DIR_EN = 5;
    localparam int CTRL_DIR_LO = 6;
    localparam int CTRL_THR_LO = 8;
    localparam int CTRL_LEGACY = 11;
    localparam int CTRL_SPEED_EN = 12;
    localparam int CTRL_PROX_NC = 13;
    // status and interrupt fields
    localparam int ST_ZERO = 0;
    localparam int ST_OVER = 1;
    localparam int ST_DIR = 2;
    localparam int ST_VALID = 3;
    localparam int ST_IDX_LO = 4;
    localparam int IRQ_ZERO = 0;
    localparam int IRQ_OVER = 1;
    localparam int IRQ_MEAS = 2;
    // reset values and limits
    localparam logic [DATA_W-1:0] CTRL_RST = 32'h0000_0000;
    localparam logic [HYST_W-1:0] HYST_RST = 7'h01;
    localparam logic [HYST_W-1:0] HYST_MAX = 7'h63;
    localparam logic [GEAR_W-1:0] GEAR_UNITY = 10'h00a;
    localparam logic [RES_W-1:0] RES_RST = 16'h0001;
    localparam logic [LIM_W-1:0] LIMIT_RST = 16'h0000;
    localparam logic [SEL_W-1:0] THR_LEGACY_M1 = 3'h3;
    // scaling constants
    localparam logic [63:0] K_SEC_PER_MIN = 64'h3c;
    localparam logic [63:0] K_MILLI = 64'h3e8;
    localparam logic [63:0] K_PCT = 64'h64;
    localparam logic [63:0] K_GEAR_DIV = 64'ha;
    // bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    typedef enum logic [2:0] {ARR_ENC, ARR_PROX, ARR_ENC_PROX, ARR_PROX_PROX, ARR_ENC_ENC} ssm_arr_t;
    typedef enum logic [1:0] {DIR_BOTH, DIR_CW, DIR_CCW} ssm_dir_t;
    typedef enum logic [1:0] {SC_ROT_ROT, SC_LIN_ROT, SC_LIN_LIN} ssm_scale_t;
endpackage
`default_nettype wire

// *** ssm_sensor_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module ssm_sensor_model (
    // clock
    input wire logic clock,
    // motion, zero half period stops the axis
    input wire logic [7:0] halfPeriod,
    input wire logic ccw,
    // sensor lines
    output logic enc1A,
    output logic enc1B,
    output logic enc2A,
    output logic prox1,
    output logic prox2
);
    logic [7:0] phaseCount = 8'h00;
    logic phase = 1'h0;
    always_ff @(posedge clock) begin
        if (halfPeriod == 8'h00) begin
            phaseCount <= 8'h00;
        end else if (phaseCount + 8'h01 >= halfPeriod) begin
            phaseCount <= 8'h00;
            phase <= ~phase;
        end else begin
            phaseCount <= phaseCount + 8'h01;
        end
    end
    // b level marks counterclockwise
    assign enc1A = phase;
    assign enc1B = ccw;
    assign enc2A = phase;
    // pnp normally open switches
    assign prox1 = phase;
    assign prox2 = phase;
endmodule
`default_nettype wire

// *** ssm_monitor_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module ssm_monitor_tb;
    import ssm_pkg::*;
    localparam int G = 64;
    logic clock = 1'h0;
    logic resetn = 1'h0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00, halfPeriod = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, got;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0, ccw = 1'h0;
    logic awready, wready, bvalid, arready, rvalid, zeroSpeed, overOk, direction, irq;
    logic enc1A, enc1B, enc2A, prox1, prox2;
    logic [1:0] bresp, rresp;
    logic [2:0] sel = 3'h0;
    int errors = 0;
    int samplesChecked = 0;
    ssm_monitor #(.GATE_LEN(G)) dut (.clock(clock), .resetn(resetn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .enc1A(enc1A), .enc1B(enc1B),
        .enc2A(enc2A), .prox1(prox1), .prox2(prox2), .threshold_sel_bit0(sel[0]), .threshold_sel_bit1(sel[1]),
        .threshold_sel_bit2(sel[2]), .zeroSpeed(zeroSpeed), .overOk(overOk), .direction(direction), .irq(irq));
    ssm_sensor_model axis (.clock(clock), .halfPeriod(halfPeriod), .ccw(ccw), .enc1A(enc1A),
        .enc1B(enc1B), .enc2A(enc2A), .prox1(prox1), .prox2(prox2));
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        samplesChecked++;
        if (g !== e) begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
        @(posedge clock);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        do begin
            @(posedge clock);
            if (awready) awvalid <= 1'h0;
            if (wready) wvalid <= 1'h0;
        end while (!bvalid);
        bready <= 1'h0;
        chk({30'h0, bresp}, {30'h0, er});
    endtask
    // write one register, let three gates pass, then look at standstill
    task automatic hold(input logic [7:0] a, input logic [31:0] d, input logic e);
        wr(a, d);
        repeat (3 * G) @(posedge clock);
        chk({31'h0, zeroSpeed}, {31'h0, e});
    endtask
    task automatic rd(input logic [7:0] a, input logic [1:0] er);
        @(posedge clock);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do begin
            @(posedge clock);
            if (arready) arvalid <= 1'h0;
        end while (!rvalid);
        got = rdata;
        rready <= 1'h0;
        chk({30'h0, rresp}, {30'h0, er});
    endtask
    task automatic give_verdict;
        if (errors == 0 && samplesChecked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial forever #25 clock = ~clock;
    initial begin
        repeat (20000) @(posedge clock);
        errors++;
        give_verdict();
    end
    initial begin
        repeat (8) @(posedge clock);
        resetn <= 1'h1;
        @(posedge clock);
        chk({28'h0, zeroSpeed, overOk, direction, irq}, 32'h0);
        rd(OFF_HYST, RESP_OKAY);
        chk(got, 32'h1);
        rd(OFF_GEAR, RESP_OKAY);
        chk(got, 32'ha);
        rd(8'h30, RESP_DECERR);
        chk(got, 32'h0);
        wr(8'h30, 32'h1, RESP_DECERR);
        wr(OFF_ZERO, 32'h258);
        for (int i = 0; i < 8; i++) begin
            wr(8'h40 + 8'(4 * i), i[0] ? 32'hea60 : 32'h12c);
        end
        wr(OFF_IRQ_MASK, 32'h1);
        wr(OFF_CTRL, 32'h1720);
        repeat (3 * G) @(posedge clock);
        chk({31'h0, zeroSpeed}, 32'h1);
        rd(OFF_IRQ_STAT, RESP_OKAY);
        halfPeriod <= 8'h2;
        ccw <= 1'h1;
        repeat (3 * G) @(posedge clock);
        chk({29'h0, zeroSpeed, direction, irq}, 32'h3);
        rd(OFF_IRQ_STAT, RESP_OKAY);
        chk(got & 32'h1, 32'h1);
        @(posedge clock);
        chk({31'h0, irq}, 32'h0);
        for (int c = 0; c < 8; c++) begin
            sel <= 3'(c);
            repeat (3 * G) @(posedge clock);
            chk({31'h0, overOk}, 32'(c % 2));
        end
        sel <= 3'h0;
        wr(OFF_CTRL, 32'h1760);
        repeat (3 * G) @(posedge clock);
        chk({31'h0, overOk}, 32'h1);
        wr(OFF_CTRL, 32'h17a0);
        repeat (3 * G) @(posedge clock);
        chk({31'h0, overOk}, 32'h0);
        sel <= 3'h7;
        wr(OFF_CTRL, 32'h1000);
        repeat (3 * G) @(posedge clock);
        chk({30'h0, overOk, direction}, 32'h0);
        sel <= 3'h6;
        wr(OFF_CTRL, 32'h1f00);
        repeat (3 * G) @(posedge clock);
        chk({31'h0, overOk}, 32'h0);
        rd(OFF_STATUS, RESP_OKAY);
        chk({29'h0, got[6:4]}, 32'h2);
        wr(OFF_CTRL, 32'h1004);
        repeat (3 * G) @(posedge clock);
        chk({31'h0, zeroSpeed}, 32'h0);
        rd(OFF_COUNT1, RESP_OKAY);
        chk(got, 32'h10);
        wr(OFF_ZERO, 32'h3e8);
        hold(OFF_CTRL, 32'h1010, 1'h1);
        hold(OFF_GEAR, 32'h5, 1'h0);
        hold(OFF_RES2, 32'h2, 1'h1);
        wr(OFF_ZERO, 32'h1);
        hold(OFF_CTRL, 32'h1001, 1'h1);
        hold(OFF_PITCH, 32'h2, 1'h0);
        hold(OFF_CTRL, 32'h1003, 1'h1);
        hold(OFF_RES1, 32'h64, 1'h0);
        halfPeriod <= 8'h0;
        repeat (3 * G) @(posedge clock);
        chk({31'h0, zeroSpeed}, 32'h1);
        give_verdict();
    end
endmodule
`default_nettype wire
